/* File: hw/flic_pkg.sv */
// constants of the four-level interrupt controller
package flic_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 24;
  localparam int NUM_PIN = 4;
  localparam int NUM_LVL = 4;
  localparam int SRC_W = 5;
  localparam int RANK_W = 2;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_TMR_PIN = 8'h88;
  localparam logic [7:0] ADR_AUX = 8'hA1;
  localparam logic [7:0] ADR_EXT_EN2 = 8'hA5;
  localparam logic [7:0] ADR_EIP2L = 8'hA6;
  localparam logic [7:0] ADR_EIP2H = 8'hA7;
  localparam logic [7:0] ADR_MAIN_EN = 8'hA8;
  localparam logic [7:0] ADR_EXT_EN1 = 8'hAD;
  localparam logic [7:0] ADR_EIP1L = 8'hAE;
  localparam logic [7:0] ADR_EIP1H = 8'hAF;
  localparam logic [7:0] ADR_IP0H = 8'hB7;
  localparam logic [7:0] ADR_IP0L = 8'hB8;
  localparam logic [7:0] ADR_PIN23 = 8'hC0;
  localparam logic [7:0] ADR_DMAPRI = 8'hC2;
  localparam logic [7:0] ADR_STATUS = 8'hC3;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int EN_GLOBAL = 7;
  localparam int EN_DMA = 6;
  localparam int TP_T0 = 0;
  localparam int TP_F0 = 1;
  localparam int TP_T1 = 2;
  localparam int TP_F1 = 3;
  localparam int XI_T2 = 0;
  localparam int XI_F2 = 1;
  localparam int XI_EN2 = 2;
  localparam int XI_POL2 = 3;
  localparam int XI_T3 = 4;
  localparam int XI_F3 = 5;
  localparam int XI_EN3 = 6;
  localparam int XI_POL3 = 7;
  localparam int AUX_POL0 = 0;
  localparam int AUX_POL1 = 1;
  localparam int AUX_BRK = 4;
  localparam int DMAPRI_LO = 6;
  localparam int DMAPRI_HI = 7;
  localparam logic [7:0] TP_FLAG_MASK = 8'h0A;
  localparam logic [7:0] XI_FLAG_MASK = 8'h22;
  localparam logic [7:0] AUX_WMASK = 8'h23;
  localparam logic [7:0] DMAPRI_MASK = 8'hC0;

  // ----------------------------------------------------------------
  // external pins: source index, flag bit, control register per pin
  // ----------------------------------------------------------------
  localparam logic [19:0] PIN_SRC_MAP = {5'h0F, 5'h06, 5'h02, 5'h00};
  localparam logic [31:0] PIN_FBIT_MAP = {8'h05, 8'h01, 8'h03, 8'h01};
  localparam logic [31:0] PIN_ADR_MAP = {ADR_PIN23, ADR_PIN23, ADR_TMR_PIN, ADR_TMR_PIN};
  localparam int PIN3 = 3;
  localparam int PIN2 = 2;

  // ----------------------------------------------------------------
  // vector table
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;

endpackage : flic_pkg

/* File: hw/flic_top.sv */
// four-level interrupt controller: enables, priorities, polling, pins
//
// Overview of operation
// - global enable clear blocks all; set lets each source through its own enable
// - every source has its own enable bit; dma in main bit 6, pin2 in control bit 2
// - priority level from high/low bit pair: 11 highest through 00 lowest
// - an active routine is never preempted by a lower level request
// - simultaneous requests of different levels: the higher level wins
// - simultaneous requests of equal level resolved by a fixed polling order
// - flags sampled every cycle, samples evaluated in the following polling cycle
// - unblocked flag found in polling cycle forces a long call to its vector
// - no vectoring while an equal or higher level routine is in progress
// - vectoring only when the polling cycle is the instruction's final cycle
// - return or enable/priority/control write delays vectoring one more instruction
// - pin 0/1 flags set on trigger, cleared on service only when edge triggered
// - type bit picks level (0) or edge (1); low/falling unless polarity set
// - polarity bit set gives high level or rising edge; clear keeps low/falling
// - pin 3 flag in edge mode set on edge, cleared when service starts, cpu may set or clear
// - asleep, pin 3 event sets flag and wakes cpu only when pin 3 enabled
// - control register holds polarity, enable, flag and type for pins 3 and 2
// - break flag set by source or software, blocks pwm, cleared only by software
// - software writes to edge-mode pin flags act like hardware updates; level mode ignores them
// - in level mode the pin flag follows the source, not cleared on entry
`timescale 1ns/1ns
module flic_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // peripheral request flags
  input wire logic [23:0] SRC_FLAGS,
  // external interrupt pins
  input wire logic EXT_PIN0_INPUT,
  input wire logic EXT_PIN1_INPUT,
  input wire logic EXT_PIN2_INPUT,
  input wire logic EXT_PIN3_INPUT,
  // cpu sequencer
  input wire logic LAST_CYCLE,
  input wire logic RETI_EXEC,
  input wire logic SLEEP_MODE,
  output logic VEC_CALL,
  output logic [15:0] VEC_ADDR,
  output logic [4:0] VEC_SRC,
  output logic WAKE_UP,
  // pwm break
  input wire logic BREAK_EVENT,
  output logic PWM_BLOCK
);

  localparam int NS = flic_pkg::NUM_SRC;
  localparam int NP = flic_pkg::NUM_PIN;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_cfg_addr(input logic [7:0] a);
    is_cfg_addr = (a == flic_pkg::ADR_MAIN_EN) || (a == flic_pkg::ADR_EXT_EN1) ||
                  (a == flic_pkg::ADR_EXT_EN2) || (a == flic_pkg::ADR_IP0L) ||
                  (a == flic_pkg::ADR_IP0H) || (a == flic_pkg::ADR_EIP1L) ||
                  (a == flic_pkg::ADR_EIP1H) || (a == flic_pkg::ADR_EIP2L) ||
                  (a == flic_pkg::ADR_EIP2H) || (a == flic_pkg::ADR_PIN23) ||
                  (a == flic_pkg::ADR_DMAPRI);
  endfunction : is_cfg_addr

  function automatic logic wr_hit(input logic w, input logic [7:0] a,
                                  input logic [7:0] target);
    wr_hit = w && (a == target);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] timer_and_pin_irq_control_reg;
  logic [7:0] aux_reg;
  logic [7:0] main_irq_enable_reg;
  logic [7:0] extended_enable_one_reg;
  logic [7:0] extended_enable_two_reg;
  logic [7:0] pin_irq_2_3_control_reg;
  logic [7:0] ip0l_reg;
  logic [7:0] ip0h_reg;
  logic [7:0] eip1l_reg;
  logic [7:0] eip1h_reg;
  logic [7:0] eip2l_reg;
  logic [7:0] eip2h_reg;
  logic [7:0] dmapri_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      timer_and_pin_irq_control_reg <= flic_pkg::RST_BYTE;
      aux_reg <= flic_pkg::RST_BYTE;
      main_irq_enable_reg <= flic_pkg::RST_BYTE;
      extended_enable_one_reg <= flic_pkg::RST_BYTE;
      extended_enable_two_reg <= flic_pkg::RST_BYTE;
      pin_irq_2_3_control_reg <= flic_pkg::RST_BYTE;
      ip0l_reg <= flic_pkg::RST_BYTE;
      ip0h_reg <= flic_pkg::RST_BYTE;
      eip1l_reg <= flic_pkg::RST_BYTE;
      eip1h_reg <= flic_pkg::RST_BYTE;
      eip2l_reg <= flic_pkg::RST_BYTE;
      eip2h_reg <= flic_pkg::RST_BYTE;
      dmapri_reg <= flic_pkg::RST_BYTE;
    end else if (WR) begin
      // flag bits live in their own flops, so they are masked out here
      unique case (ADDR)
        flic_pkg::ADR_TMR_PIN: timer_and_pin_irq_control_reg <= WDATA & ~flic_pkg::TP_FLAG_MASK;
        flic_pkg::ADR_AUX: aux_reg <= WDATA & flic_pkg::AUX_WMASK;
        flic_pkg::ADR_MAIN_EN: main_irq_enable_reg <= WDATA;
        flic_pkg::ADR_EXT_EN1: extended_enable_one_reg <= WDATA;
        flic_pkg::ADR_EXT_EN2: extended_enable_two_reg <= WDATA;
        flic_pkg::ADR_PIN23: pin_irq_2_3_control_reg <= WDATA & ~flic_pkg::XI_FLAG_MASK;
        flic_pkg::ADR_IP0L: ip0l_reg <= WDATA;
        flic_pkg::ADR_IP0H: ip0h_reg <= WDATA;
        flic_pkg::ADR_EIP1L: eip1l_reg <= WDATA;
        flic_pkg::ADR_EIP1H: eip1h_reg <= WDATA;
        flic_pkg::ADR_EIP2L: eip2l_reg <= WDATA;
        flic_pkg::ADR_EIP2H: eip2h_reg <= WDATA;
        flic_pkg::ADR_DMAPRI: dmapri_reg <= WDATA & flic_pkg::DMAPRI_MASK;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // source maps: enables and priority bit pairs in polling order
  // ----------------------------------------------------------------
  logic [NS-1:0] src_en;
  logic [NS-1:0] pri_hi;
  logic [NS-1:0] pri_lo;

  // one enable per source; reserved slots 20..22 tied off
  assign src_en = {extended_enable_two_reg[6], 3'b000, extended_enable_two_reg[5],
                   main_irq_enable_reg[flic_pkg::EN_DMA], extended_enable_two_reg[1:0],
                   pin_irq_2_3_control_reg[flic_pkg::XI_EN3], extended_enable_one_reg[4],
                   extended_enable_one_reg[7:5], extended_enable_one_reg[3:0],
                   pin_irq_2_3_control_reg[flic_pkg::XI_EN2], main_irq_enable_reg[5:0]};
  // high and low bit of each source
  assign pri_hi = {eip2h_reg[6], 3'b000, eip2h_reg[5],
                   dmapri_reg[flic_pkg::DMAPRI_HI], eip2h_reg[1:0], ip0h_reg[7],
                   eip1h_reg[4], eip1h_reg[7:5], eip1h_reg[3:0], ip0h_reg[6:0]};
  assign pri_lo = {eip2l_reg[6], 3'b000, eip2l_reg[5],
                   dmapri_reg[flic_pkg::DMAPRI_LO], eip2l_reg[1:0], ip0l_reg[7],
                   eip1l_reg[4], eip1l_reg[7:5], eip1l_reg[3:0], ip0l_reg[6:0]};

  // ----------------------------------------------------------------
  // external pins: synchroniser, polarity, trigger detect
  // ----------------------------------------------------------------
  logic [NP-1:0] pin_sync1_reg;
  logic [NP-1:0] pin_sync2_reg;
  logic [NP-1:0] pin_act_prev_reg;
  logic [NP-1:0] pin_flag_reg;
  logic [NP-1:0] pin_type;
  logic [NP-1:0] pin_pol;
  logic [NP-1:0] pin_act;
  logic [NP-1:0] pin_edge;

  assign pin_type = {pin_irq_2_3_control_reg[flic_pkg::XI_T3],
                     pin_irq_2_3_control_reg[flic_pkg::XI_T2],
                     timer_and_pin_irq_control_reg[flic_pkg::TP_T1],
                     timer_and_pin_irq_control_reg[flic_pkg::TP_T0]};
  // pin 2/3 polarity in the pin control register
  assign pin_pol = {pin_irq_2_3_control_reg[flic_pkg::XI_POL3],
                    pin_irq_2_3_control_reg[flic_pkg::XI_POL2],
                    aux_reg[flic_pkg::AUX_POL1], aux_reg[flic_pkg::AUX_POL0]};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      // idle high, so the default low-active sense sees no request after reset
      pin_sync1_reg <= '1;
      pin_sync2_reg <= '1;
    end else begin
      pin_sync1_reg <= {EXT_PIN3_INPUT, EXT_PIN2_INPUT, EXT_PIN1_INPUT, EXT_PIN0_INPUT};
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  // low or falling unless polarity set
  // polarity set inverts the sense to high or rising
  assign pin_act = pin_pol ~^ pin_sync2_reg;
  assign pin_edge = pin_act & ~pin_act_prev_reg;

  // previous level starts active, yet a pin idling low still gives one edge once the synchroniser drains its reset value
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_act_prev_reg <= '1;
    end else begin
      pin_act_prev_reg <= pin_act;
    end
  end

  // ----------------------------------------------------------------
  // vector decision (declared early, used by flag clearing)
  // ----------------------------------------------------------------
  logic fire;
  logic [flic_pkg::SRC_W-1:0] best_idx;
  logic [flic_pkg::RANK_W-1:0] best_rank;
  logic best_found;

  // ----------------------------------------------------------------
  // pin request flags
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_pin
      localparam logic [flic_pkg::SRC_W-1:0] SIDX =
        flic_pkg::PIN_SRC_MAP[gp*flic_pkg::SRC_W +: flic_pkg::SRC_W];
      localparam int FBIT = int'(flic_pkg::PIN_FBIT_MAP[gp*8 +: 8]);
      localparam logic [7:0] FADR = flic_pkg::PIN_ADR_MAP[gp*8 +: 8];
      logic sw_wr;
      logic hw_clr;
      assign sw_wr = wr_hit(WR, ADDR, FADR);
      assign hw_clr = fire && (best_idx == SIDX);
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          pin_flag_reg[gp] <= 1'b0;
        end else if (!pin_type[gp]) begin
          // level mode, flag tracks the pin itself
          pin_flag_reg[gp] <= pin_act[gp];
        end else if (pin_edge[gp]) begin
          // edge sets the flag, set wins over any clear
          pin_flag_reg[gp] <= 1'b1;
        end else if (sw_wr) begin
          // software write behaves like a hardware update
          pin_flag_reg[gp] <= WDATA[FBIT];
        end else if (hw_clr) begin
          // edge flag cleared when its service starts
          pin_flag_reg[gp] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // flag sampling and polling
  // ----------------------------------------------------------------
  logic [NS-1:0] flags_now;
  logic [NS-1:0] sample_reg;
  logic [NS-1:0] req;

  always_comb begin
    flags_now = SRC_FLAGS;
    for (int i = 0; i < NP; i++) begin
      flags_now[flic_pkg::PIN_SRC_MAP[i*flic_pkg::SRC_W +: flic_pkg::SRC_W]] = pin_flag_reg[i];
    end
  end

  // sample every cycle, evaluate in the next
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sample_reg <= '0;
    end else begin
      sample_reg <= flags_now;
    end
  end

  assign req = main_irq_enable_reg[flic_pkg::EN_GLOBAL] ? (sample_reg & src_en) : '0;

  // strict compare keeps the lowest index on a tie
  always_comb begin
    best_found = 1'b0;
    best_idx = '0;
    best_rank = '0;
    for (int i = 0; i < NS; i++) begin
      if (req[i] && (!best_found || {pri_hi[i], pri_lo[i]} > best_rank)) begin
        best_found = 1'b1;
        best_idx = flic_pkg::SRC_W'(i);
        best_rank = {pri_hi[i], pri_lo[i]};
      end
    end
  end

  // ----------------------------------------------------------------
  // in-service tracking and block conditions
  // ----------------------------------------------------------------
  logic [flic_pkg::NUM_LVL-1:0] in_svc_reg;
  logic [flic_pkg::NUM_LVL-1:0] in_svc_next;
  logic svc_any;
  logic [flic_pkg::RANK_W-1:0] svc_top;
  logic cfg_seen_reg;
  logic cfg_wr;
  logic delay_blk;
  logic level_ok;

  always_comb begin
    svc_any = 1'b0;
    svc_top = '0;
    for (int l = 0; l < flic_pkg::NUM_LVL; l++) begin
      if (in_svc_reg[l]) begin
        svc_any = 1'b1;
        svc_top = flic_pkg::RANK_W'(l);
      end
    end
  end

  // equal or higher level in progress blocks
  assign level_ok = !svc_any || (best_rank > svc_top);

  // return or config write in this instruction delays one more
  assign cfg_wr = WR && is_cfg_addr(ADDR);
  assign delay_blk = RETI_EXEC || cfg_wr || cfg_seen_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg_seen_reg <= 1'b0;
    end else if (LAST_CYCLE) begin
      cfg_seen_reg <= 1'b0;
    end else if (cfg_wr) begin
      cfg_seen_reg <= 1'b1;
    end
  end

  // unblocked request found in polling cycle makes the call
  // only on the instruction's final cycle
  assign fire = best_found && level_ok && LAST_CYCLE && !delay_blk;

  // return pops the top level; a call pushes the granted level
  always_comb begin
    in_svc_next = in_svc_reg;
    if (RETI_EXEC && LAST_CYCLE && svc_any) begin
      in_svc_next[svc_top] = 1'b0;
    end
    if (fire) begin
      in_svc_next[best_rank] = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      in_svc_reg <= '0;
    end else begin
      in_svc_reg <= in_svc_next;
    end
  end

  // ----------------------------------------------------------------
  // call outputs
  // ----------------------------------------------------------------
  // vector address from source index
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      VEC_CALL <= 1'b0;
      VEC_ADDR <= flic_pkg::VEC_BASE;
      VEC_SRC <= '0;
    end else begin
      VEC_CALL <= fire;
      if (fire) begin
        VEC_ADDR <= flic_pkg::VEC_BASE + (16'(best_idx) << flic_pkg::VEC_SHIFT);
        VEC_SRC <= best_idx;
      end
    end
  end

  // ----------------------------------------------------------------
  // wake-up and pwm break
  // ----------------------------------------------------------------
  logic brk_flag_reg;

  // only an enabled pin 3 (or pin 2) flag wakes the cpu
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WAKE_UP <= 1'b0;
    end else begin
      WAKE_UP <= SLEEP_MODE &&
                 ((pin_flag_reg[flic_pkg::PIN3] && pin_irq_2_3_control_reg[flic_pkg::XI_EN3]) ||
                  (pin_flag_reg[flic_pkg::PIN2] && pin_irq_2_3_control_reg[flic_pkg::XI_EN2]));
    end
  end

  // break source sets, software sets or clears, set wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      brk_flag_reg <= 1'b0;
    end else if (BREAK_EVENT) begin
      brk_flag_reg <= 1'b1;
    end else if (wr_hit(WR, ADDR, flic_pkg::ADR_AUX)) begin
      brk_flag_reg <= WDATA[flic_pkg::AUX_BRK];
    end
  end

  // pwm channels blocked while the flag stands
  assign PWM_BLOCK = brk_flag_reg;

  // ----------------------------------------------------------------
  // read port: data one cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    unique case (ADDR)
      flic_pkg::ADR_TMR_PIN: rd_mux = timer_and_pin_irq_control_reg |
        ({4'h0, pin_flag_reg[1], 1'b0, pin_flag_reg[0], 1'b0} & flic_pkg::TP_FLAG_MASK);
      flic_pkg::ADR_AUX: rd_mux = aux_reg | {3'b000, brk_flag_reg, 4'h0};
      flic_pkg::ADR_MAIN_EN: rd_mux = main_irq_enable_reg;
      flic_pkg::ADR_EXT_EN1: rd_mux = extended_enable_one_reg;
      flic_pkg::ADR_EXT_EN2: rd_mux = extended_enable_two_reg;
      flic_pkg::ADR_PIN23: rd_mux = pin_irq_2_3_control_reg |
        ({2'b00, pin_flag_reg[3], 3'b000, pin_flag_reg[2], 1'b0} & flic_pkg::XI_FLAG_MASK);
      flic_pkg::ADR_IP0L: rd_mux = ip0l_reg;
      flic_pkg::ADR_IP0H: rd_mux = ip0h_reg;
      flic_pkg::ADR_EIP1L: rd_mux = eip1l_reg;
      flic_pkg::ADR_EIP1H: rd_mux = eip1h_reg;
      flic_pkg::ADR_EIP2L: rd_mux = eip2l_reg;
      flic_pkg::ADR_EIP2H: rd_mux = eip2h_reg;
      flic_pkg::ADR_DMAPRI: rd_mux = dmapri_reg;
      flic_pkg::ADR_STATUS: rd_mux = {4'h0, in_svc_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule : flic_top

/* File: tb/flic_checker.sv */
// port assertions of the interrupt controller
`timescale 1ns/1ns
module flic_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  // cpu side
  input wire logic LAST_CYCLE,
  input wire logic RETI_EXEC,
  input wire logic SLEEP_MODE,
  input wire logic VEC_CALL,
  input wire logic [15:0] VEC_ADDR,
  input wire logic [4:0] VEC_SRC,
  input wire logic WAKE_UP,
  // pwm break
  input wire logic BREAK_EVENT,
  input wire logic PWM_BLOCK
);
  logic ge_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------
  // helper: shadow of the global enable
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ge_reg <= 1'b0;
    end else if (WR && ADDR == flic_pkg::ADR_MAIN_EN) begin
      ge_reg <= WDATA[flic_pkg::EN_GLOBAL];
    end
  end
  sequence s_aux_wr;
    WR && ADDR == flic_pkg::ADR_AUX;
  endsequence
  sequence s_brk_clr;
    s_aux_wr ##0 (!WDATA[flic_pkg::AUX_BRK] && !BREAK_EVENT);
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_call_last: assert property (VEC_CALL |-> $past(LAST_CYCLE))
    else $error("call outside final instruction cycle");
  chk_call_reti: assert property (VEC_CALL |-> !$past(RETI_EXEC))
    else $error("call right after return");
  chk_call_gate: assert property (VEC_CALL |-> $past(ge_reg))
    else $error("call with global enable clear");
  chk_vec_calc: assert property (VEC_CALL |->
    VEC_ADDR == flic_pkg::VEC_BASE + {8'h00, VEC_SRC, 3'b000})
    else $error("vector address wrong");
  chk_vec_hold: assert property (!VEC_CALL |-> $stable(VEC_ADDR) && $stable(VEC_SRC))
    else $error("vector moved without call");
  chk_no_reserved: assert property (VEC_CALL |-> VEC_SRC < 5'd20 || VEC_SRC == 5'd23)
    else $error("call to reserved source");
  chk_brk_set: assert property (BREAK_EVENT |=> PWM_BLOCK)
    else $error("break not flagged");
  chk_brk_clear: assert property (s_brk_clr |=> !PWM_BLOCK)
    else $error("break flag not cleared by write");
  chk_brk_hold: assert property (PWM_BLOCK && !(WR && ADDR == flic_pkg::ADR_AUX)
    |=> PWM_BLOCK)
    else $error("break flag dropped by itself");
  chk_wake_gate: assert property (WAKE_UP |-> $past(SLEEP_MODE))
    else $error("wake while awake");
endmodule : flic_checker

bind flic_top flic_checker chk_i (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .LAST_CYCLE(LAST_CYCLE), .RETI_EXEC(RETI_EXEC), .SLEEP_MODE(SLEEP_MODE),
  .VEC_CALL(VEC_CALL), .VEC_ADDR(VEC_ADDR), .VEC_SRC(VEC_SRC), .WAKE_UP(WAKE_UP),
  .BREAK_EVENT(BREAK_EVENT), .PWM_BLOCK(PWM_BLOCK));

/* File: tb/flic_cpu_model.sv */
// cpu sequencer model: instruction length, return, call count
`timescale 1ns/1ns
module flic_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic [3:0] ilen,
  input wire logic reti_req,
  // controller side
  input wire logic vec_call,
  output logic last_cycle,
  output logic reti_exec,
  output logic [7:0] ncall
);
  logic [3:0] cnt_reg;
  assign last_cycle = (cnt_reg >= ilen - 4'h1);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      reti_exec <= 1'b0;
    end else if (last_cycle) begin
      cnt_reg <= 4'h0;
      reti_exec <= reti_req;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ncall <= 8'h00;
    end else if (vec_call) begin
      ncall <= ncall + 8'h01;
    end
  end
endmodule : flic_cpu_model

/* File: tb/flic_top_test.sv */
// self-checking bench of the interrupt controller
`timescale 1ns/1ns
module flic_top_test;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sleep = 1'b0, brk = 1'b0;
  logic reti_req = 1'b0, last, reti, call, wake, pblk;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ncall, d;
  logic [23:0] flags = 24'h00_0000;
  logic [3:0] pin = 4'hF, ilen = 4'h3;
  logic [15:0] vaddr;
  logic [4:0] vsrc;
  int fails = 0, compares = 0, i;
  always #5 clk = ~clk;
  flic_top dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SRC_FLAGS(flags), .EXT_PIN0_INPUT(pin[0]), .EXT_PIN1_INPUT(pin[1]),
    .EXT_PIN2_INPUT(pin[2]), .EXT_PIN3_INPUT(pin[3]), .LAST_CYCLE(last),
    .RETI_EXEC(reti), .SLEEP_MODE(sleep), .VEC_CALL(call), .VEC_ADDR(vaddr),
    .VEC_SRC(vsrc), .WAKE_UP(wake), .BREAK_EVENT(brk), .PWM_BLOCK(pblk));
  flic_cpu_model cpu (.clk(clk), .rst(rst), .ilen(ilen), .reti_req(reti_req),
    .vec_call(call), .last_cycle(last), .reti_exec(reti), .ncall(ncall));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wrr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rchk
  // bounded wait for a call, then source and vector
  task wcall(input logic [4:0] s);
    i = 0;
    while (call !== 1'b1 && i < 80) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i >= 80) begin
      fails++;
      end_sim();
    end
    chk({11'h000, vsrc}, {11'h000, s});
    chk(vaddr, 16'h0003 + {8'h00, s, 3'b000});
  endtask : wcall
  task nocall;
    d = ncall;
    repeat (20) @(posedge clk);
    #1;
    chk({8'h00, ncall}, {8'h00, d});
  endtask : nocall
  // one return instruction, two when ilen is 1; no trailing wait so a call is not missed
  task pop;
    @(posedge clk);
    reti_req <= 1'b1;
    i = 0;
    while (reti !== 1'b1 && i < 40) begin
      @(posedge clk);
      i++;
    end
    if (i >= 40) begin
      fails++;
      end_sim();
    end
    reti_req <= 1'b0;
  endtask : pop
  task clean;
    @(posedge clk);
    flags <= 24'h00_0000;
    pop();
    repeat (12) @(posedge clk);
    rchk(8'hC3, 8'h00);
    wrr(8'hA8, 8'h00);
  endtask : clean
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h88, 8'h00);
    rchk(8'hA1, 8'h00);
    rchk(8'hA8, 8'h00);
    rchk(8'hC0, 8'h00);
    rchk(8'h90, 8'h00);
    wrr(8'hA8, 8'h81);
    rchk(8'hA8, 8'h81);
    $display("test registers done");
    wrr(8'hA8, 8'h02);
    flags <= 24'h00_0002;
    nocall();
    wrr(8'hA8, 8'h82);
    wcall(5'd1);
    rchk(8'hC3, 8'h01);
    nocall();
    pop();
    wcall(5'd1);
    clean();
    $display("test gating done");
    wrr(8'hB7, 8'h08);
    wrr(8'hB8, 8'h08);
    flags <= 24'h00_000A;
    wrr(8'hA8, 8'h8A);
    wcall(5'd3);
    rchk(8'hC3, 8'h08);
    @(posedge clk);
    flags <= 24'h00_0002;
    nocall();
    pop();
    wcall(5'd1);
    clean();
    flags <= 24'h00_0030;
    wrr(8'hA8, 8'hB0);
    wcall(5'd4);
    clean();
    flags <= 24'h04_0000;
    wrr(8'hA8, 8'hC0);
    wcall(5'd18);
    clean();
    $display("test priority done");
    ilen <= 4'h1;
    wrr(8'h88, 8'h01);
    pin[0] <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(8'h88, 8'h03);
    wrr(8'hA8, 8'h81);
    wcall(5'd0);
    rchk(8'h88, 8'h01);
    wrr(8'hA8, 8'h00);
    pop();
    wrr(8'hA1, 8'h01);
    pin[0] <= 1'b1;
    repeat (6) @(posedge clk);
    rchk(8'h88, 8'h03);
    wrr(8'h88, 8'h00);
    rchk(8'h88, 8'h02);
    @(posedge clk);
    pin[0] <= 1'b0;
    repeat (4) @(posedge clk);
    rchk(8'h88, 8'h00);
    wrr(8'hA1, 8'h00);
    pin[0] <= 1'b1;
    $display("test pins done");
    sleep <= 1'b1;
    wrr(8'hC0, 8'h10);
    pin[3] <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(8'hC0, 8'h30);
    chk({15'h0000, wake}, 16'h0000);
    wrr(8'hC0, 8'h70);
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0000, wake}, 16'h0001);
    wrr(8'hC0, 8'h50);
    rchk(8'hC0, 8'h50);
    wrr(8'hC0, 8'h70);
    rchk(8'hC0, 8'h70);
    @(posedge clk);
    sleep <= 1'b0;
    $display("test wake done");
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    rchk(8'hA1, 8'h10);
    wrr(8'hA1, 8'h00);
    rchk(8'hA1, 8'h00);
    wrr(8'hA1, 8'h10);
    #1;
    chk({15'h0000, pblk}, 16'h0001);
    $display("test break done");
    end_sim();
  end
endmodule : flic_top_test
